// ### hdl/ctrl_input_qualifier.sv
// Enable gating and minimum-hold qualification of the two control inputs
`timescale 1ns/1ns
module ctrl_input_qualifier
    import gauge_seq_pkg::*;
#(
    parameter int HOLD_CYCLES = MIN_HOLD_CYCLES
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic ext_enable,
    input  wire logic [1:0] ctrl_in,
    hold_if.filt      q
);
    // A zero hold would pass two-cycle glitches as steps
    if (HOLD_CYCLES < 1) begin
        $error("HOLD_CYCLES must be at least 1");
    end

    logic [1:0]  cand_reg;
    logic [1:0]  acc_reg;
    logic [31:0] cnt_reg;
    logic        step_reg;
    logic        rej_reg;

    wire logic   changed  = ctrl_in != cand_reg;
    wire logic   held     = cnt_reg >= 32'(HOLD_CYCLES);
    wire logic   pending  = cand_reg != acc_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cand_reg <= 2'h0;
            acc_reg  <= 2'h0;
            cnt_reg  <= 32'h0000_0000;
            step_reg <= 1'b0;
            rej_reg  <= 1'b0;
        end else if (ce) begin
            step_reg <= 1'b0;
            rej_reg  <= 1'b0;
            if (!ext_enable) begin
                cand_reg <= acc_reg;
                cnt_reg  <= 32'h0000_0000;
            end else if (changed) begin
                rej_reg  <= pending && !held;
                cand_reg <= ctrl_in;
                cnt_reg  <= 32'h0000_0000;
            end else if (pending && held) begin
                acc_reg  <= cand_reg;
                step_reg <= 1'b1;
            end else if (!held) begin
                cnt_reg <= cnt_reg + 32'h0000_0001;
            end
        end
    end

    assign q.state  = acc_reg;
    assign q.step   = step_reg;
    assign q.reject = rej_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_step_needs_enable: assert property (@(posedge mclk) disable iff (srst)
        ce && !ext_enable |=> !step_reg)
        else $error("step applied without enable");
    a_step_after_hold: assert property (@(posedge mclk) disable iff (srst)
        $rose(step_reg) |-> $past(held))
        else $error("step applied before hold elapsed");
    a_reject_short: assert property (@(posedge mclk) disable iff (srst)
        rej_reg |-> !step_reg)
        else $error("rejected step also applied");
endmodule

// ### hdl/gauge_calibration_mode_sequencer.sv
// Gauge calibration and operating-mode sequencer with APB register access
// ------------------------------------------------------------
// Notes on behaviour
// - Code 0002 from auto: thermal only, check
// - Code 4002 after 0002: run correction
// - Second 0002 after correction: store value
// - Code 0009: auto range, auto filament
// - Input changes need enable held high
// - Input one alone: thermal only, check
// - Input two with one: full-scale correction
// - Drop two, keep one: store value
// - Drop one last: back to auto range
// - Zero point: one, two alone, one, release
// - Auto range switches branches at switchover
// - Single-branch mode never enters ionisation
// - Indicator red thermal, green ionisation
// - Panel calibration ends on its own
// - Auto return selects filament automatically
// ------------------------------------------------------------
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module gauge_calibration_mode_sequencer
    import gauge_seq_pkg::*;
#(
    parameter int HOLD_CYCLES = MIN_HOLD_CYCLES,
    parameter int RUN_CYCLES  = CORRECT_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_enable,
    input  wire logic        ctrl_in1,
    input  wire logic        ctrl_in2,
    input  wire logic        switchover_reached,
    output logic             thermal_only,
    output logic             ion_branch_active,
    output logic             led_red,
    output logic             led_green,
    output logic             automatic_filament_choice,
    output logic             correct_pulse,
    output logic             store_pulse,
    output logic             adjust_in_progress_message
);
    // Run counter is 16 bits wide
    if (RUN_CYCLES < 1 || RUN_CYCLES > 65536) begin
        $error("RUN_CYCLES must lie in 1 to 65536");
    end

    // ------------------------------------------------------------
    // Control input qualification
    // ------------------------------------------------------------
    hold_if hq ();

    ctrl_input_qualifier #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_qual (
        .mclk       (mclk),
        .srst       (srst),
        .ce         (ce),
        .ext_enable (ext_enable),
        .ctrl_in    ({ctrl_in2, ctrl_in1}),
        .q          (hq.filt)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Write lands on the first access edge; pready answers a cycle later
    // Gating with pready keeps a long access from being taken twice
    wire logic  acc_phase = psel && penable && !pready;
    wire logic  hit_cmd   = paddr == CMD_OFFSET;
    wire logic  hit_st    = paddr == STATUS_OFFSET;
    wire logic  hit_ctrl  = paddr == CTRL_OFFSET;
    wire logic  mapped    = hit_cmd || hit_st || hit_ctrl;
    wire logic  wr_cmd    = acc_phase && pwrite && hit_cmd;
    wire logic  wr_ctrl   = acc_phase && pwrite && hit_ctrl;
    wire logic [15:0] cmd = pwdata[15:0];

    stage_type   stage_reg, stage_next;
    logic        zero_reg, zero_next;
    logic        stored_reg;
    logic        reject_reg;
    logic [31:0] ctrl_reg;
    logic [15:0] run_cnt_reg;
    logic        ion_reg;

    // ------------------------------------------------------------
    // Stage sequencing
    // ------------------------------------------------------------
    wire logic [1:0] inp = hq.state;
    wire logic panel_go  = wr_ctrl && pwdata[CTRL_PANEL_START_BIT]
                           && stage_reg == ST_AUTO;
    wire logic run_done  = run_cnt_reg == 16'(RUN_CYCLES - 1);

    // One-cycle strobe on entry into a stage
    function automatic logic enters(input stage_type nxt, input stage_type cur,
                                    input stage_type s);
        return nxt == s && cur != s;
    endfunction

    always_comb begin
        stage_next = stage_reg;
        zero_next  = zero_reg;
        if (wr_cmd) begin
            unique case (stage_reg)
                ST_AUTO: begin
                    if (cmd == CMD_THERMAL_ONLY) stage_next = ST_CHECK;
                end
                ST_CHECK: begin
                    if (cmd == CMD_CORRECT) stage_next = ST_CORRECT;
                end
                ST_CORRECT: begin
                    if (cmd == CMD_THERMAL_ONLY) stage_next = ST_STORE;
                end
                ST_STORE, ST_PANEL_RUN: ;
            endcase
            if (cmd == CMD_AUTO_RANGE && stage_reg != ST_PANEL_RUN) stage_next = ST_AUTO;
        end else if (hq.step) begin
            unique case (inp)
                2'b01: begin
                    if (stage_reg == ST_AUTO) stage_next = ST_CHECK;
                    else if (stage_reg == ST_CORRECT) stage_next = ST_STORE;
                end
                2'b11: begin
                    if (stage_reg == ST_CHECK) begin
                        stage_next = ST_CORRECT;
                        zero_next  = 1'b0;
                    end
                end
                2'b10: begin
                    if (stage_reg == ST_CHECK) begin
                        stage_next = ST_CORRECT;
                        zero_next  = 1'b1;
                    end
                end
                2'b00: begin
                    if (stage_reg != ST_PANEL_RUN) stage_next = ST_AUTO;
                end
            endcase
        end else if (panel_go) begin
            stage_next = ST_PANEL_RUN;
            zero_next  = pwdata[CTRL_PANEL_ZERO_BIT];
        end else if (stage_reg == ST_PANEL_RUN && run_done) begin
            stage_next = ST_AUTO;
        end
    end

    wire logic thermal_next = stage_next != ST_AUTO;
    wire logic ion_next     = !thermal_next && switchover_reached;

    always_ff @(posedge mclk) begin
        if (srst) begin
            stage_reg  <= ST_AUTO;
            zero_reg   <= 1'b0;
            stored_reg <= 1'b0;
            ion_reg    <= 1'b0;
            run_cnt_reg <= 16'h0000;
        end else if (ce) begin
            stage_reg  <= stage_next;
            zero_reg   <= zero_next;
            ion_reg    <= ion_next;
            if (enters(stage_next, stage_reg, ST_STORE)) stored_reg <= 1'b1;
            else if (stage_next == ST_CHECK) stored_reg <= 1'b0;
            if (stage_reg == ST_PANEL_RUN) run_cnt_reg <= run_cnt_reg + 16'h0001;
            else run_cnt_reg <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            thermal_only               <= 1'b0;
            ion_branch_active          <= 1'b0;
            // Auto mode measures on the thermal branch, so red from reset on
            led_red                    <= 1'b1;
            led_green                  <= 1'b0;
            automatic_filament_choice  <= 1'b1;
            correct_pulse              <= 1'b0;
            store_pulse                <= 1'b0;
            adjust_in_progress_message <= 1'b0;
        end else if (ce) begin
            thermal_only      <= thermal_next;
            ion_branch_active <= ion_next;
            led_red           <= !ion_next;
            led_green         <= ion_next;
            automatic_filament_choice <= !thermal_next;
            correct_pulse <= enters(stage_next, stage_reg, ST_CORRECT)
                             || enters(stage_next, stage_reg, ST_PANEL_RUN);
            store_pulse   <= enters(stage_next, stage_reg, ST_STORE)
                             || (stage_reg == ST_PANEL_RUN && stage_next == ST_AUTO);
            adjust_in_progress_message <= stage_next == ST_PANEL_RUN;
        end
    end

    // ------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------
    wire logic [31:0] status_word = {20'h0_0000, reject_reg, adjust_in_progress_message,
                                     stored_reg, zero_reg, led_green, led_red,
                                     ion_branch_active, thermal_only,
                                     1'b0, stage_reg};

    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            ctrl_reg   <= CTRL_RESET;
            reject_reg <= 1'b0;
        end else if (ce) begin
            pready  <= acc_phase;
            pslverr <= acc_phase && !mapped;
            if (wr_ctrl) ctrl_reg <= pwdata;
            // Sticky reject: a new reject wins over a clearing read
            if (hq.reject) reject_reg <= 1'b1;
            else if (acc_phase && !pwrite && hit_st) reject_reg <= 1'b0;
            if (acc_phase && !pwrite) begin
                prdata <= hit_st ? status_word :
                          hit_ctrl ? ctrl_reg : 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_cmd_enter_check: assert property (@(posedge mclk) disable iff (srst)
        ce && wr_cmd && cmd == CMD_THERMAL_ONLY && stage_reg == ST_AUTO
        |=> stage_reg == ST_CHECK && thermal_only)
        else $error("0002 did not enter check");
    a_cmd_correct: assert property (@(posedge mclk) disable iff (srst)
        ce && wr_cmd && cmd == CMD_CORRECT && stage_reg == ST_CHECK |=> correct_pulse)
        else $error("4002 did not start correction");
    a_cmd_store: assert property (@(posedge mclk) disable iff (srst)
        ce && wr_cmd && cmd == CMD_THERMAL_ONLY && stage_reg == ST_CORRECT
        |=> store_pulse && thermal_only)
        else $error("repeat 0002 did not store");
    a_cmd_auto: assert property (@(posedge mclk) disable iff (srst)
        ce && wr_cmd && cmd == CMD_AUTO_RANGE && stage_reg != ST_PANEL_RUN
        |=> !thermal_only && automatic_filament_choice)
        else $error("0009 did not return auto");
    a_thermal_no_ion: assert property (@(posedge mclk) disable iff (srst)
        thermal_only |-> !ion_branch_active)
        else $error("ionisation in thermal mode");
    a_led_colour: assert property (@(posedge mclk) disable iff (srst)
        led_green == ion_branch_active && led_red == !ion_branch_active)
        else $error("indicator colour wrong");
    a_panel_ends: assert property (@(posedge mclk) disable iff (srst)
        $rose(adjust_in_progress_message) |-> ##[1:1000] !adjust_in_progress_message)
        else $error("panel run did not end");
    a_input_one_check: assert property (@(posedge mclk) disable iff (srst)
        ce && hq.step && inp == 2'b01 && stage_reg == ST_AUTO && !wr_cmd
        |=> stage_reg == ST_CHECK)
        else $error("input one did not enter check");
    a_input_full_scale: assert property (@(posedge mclk) disable iff (srst)
        ce && hq.step && inp == 2'b11 && stage_reg == ST_CHECK && !wr_cmd
        |=> correct_pulse && !zero_reg)
        else $error("inputs one and two did not start correction");
    a_input_store: assert property (@(posedge mclk) disable iff (srst)
        ce && hq.step && inp == 2'b01 && stage_reg == ST_CORRECT && !wr_cmd
        |=> store_pulse && thermal_only)
        else $error("input one alone did not store");
    a_input_release: assert property (@(posedge mclk) disable iff (srst)
        ce && hq.step && inp == 2'b00 && stage_reg != ST_PANEL_RUN && !wr_cmd
        |=> !thermal_only && automatic_filament_choice)
        else $error("release did not return auto");
    a_input_zero: assert property (@(posedge mclk) disable iff (srst)
        ce && hq.step && inp == 2'b10 && stage_reg == ST_CHECK && !wr_cmd
        |=> correct_pulse && zero_reg)
        else $error("input two alone did not start zero correction");
    a_auto_ion: assert property (@(posedge mclk) disable iff (srst)
        ce && stage_next == ST_AUTO && switchover_reached |=> ion_branch_active)
        else $error("no ionisation branch at switchover");

    c_serial_store: cover property (@(posedge mclk) store_pulse && !ctrl_in1);
    c_full_scale:   cover property (@(posedge mclk) hq.step && inp == 2'b11);
    c_serial_auto:  cover property (@(posedge mclk) wr_cmd && cmd == CMD_AUTO_RANGE);
    c_input_zero:   cover property (@(posedge mclk) hq.step && inp == 2'b10);
    c_panel_run:    cover property (@(posedge mclk) $fell(adjust_in_progress_message));
endmodule

// ### hdl/gauge_seq_pkg.sv
// Constants and types shared by the gauge calibration mode sequencer
package gauge_seq_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OFFSET    = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CTRL_OFFSET   = 8'h08;

    // ------------------------------------------------------------
    // Command codes and fields
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_THERMAL_ONLY = 16'h0002;
    localparam logic [15:0] CMD_CORRECT      = 16'h4002;
    localparam logic [15:0] CMD_AUTO_RANGE   = 16'h0009;
    localparam int          CTRL_PANEL_START_BIT = 0;
    localparam int          CTRL_PANEL_ZERO_BIT  = 1;
    localparam int          ST_STAGE_LSB     = 0;
    localparam int          ST_THERMAL_BIT   = 4;
    localparam int          ST_ION_BIT       = 5;
    localparam int          ST_RED_BIT       = 6;
    localparam int          ST_GREEN_BIT     = 7;
    localparam int          ST_ZERO_BIT      = 8;
    localparam int          ST_STORED_BIT    = 9;
    localparam int          ST_RUN_BIT       = 10;
    localparam int          ST_REJECT_BIT    = 11;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MCLK_MHZ          = 250;
    localparam int MIN_HOLD_MS       = 2000;
    localparam int MIN_HOLD_CYCLES   = MIN_HOLD_MS * 1000 * MCLK_MHZ + 1;
    localparam int CORRECT_CYCLES    = 64;

    typedef enum logic [2:0] {
        ST_AUTO,
        ST_CHECK,
        ST_CORRECT,
        ST_STORE,
        ST_PANEL_RUN
    } stage_type;

endpackage

// ### hdl/hold_if.sv
// Interface carrying the qualified control-input step to the sequencer
`timescale 1ns/1ns
interface hold_if;
    logic [1:0] state;
    logic       step;
    logic       reject;
    modport filt (output state, output step, output reject);
    modport seq  (input state, input step, input reject);
endinterface

// ### verif/operator_model.sv
// Operator model driving the gated control inputs
`timescale 1ns/1ns
module operator_model (
    input  wire logic mclk,
    output logic      ext_enable,
    output logic      ctrl_in1,
    output logic      ctrl_in2
);
    initial begin
        ext_enable = 1'b1;
        ctrl_in1   = 1'b0;
        ctrl_in2   = 1'b0;
    end

    // ------------------------------------------------------------
    // Step driver
    // ------------------------------------------------------------
    // enable set on the same edge as the inputs, then both held for hold edges
    task automatic apply(input logic en, input logic [1:0] val, input int hold);
        @(posedge mclk);
        ext_enable <= en;
        ctrl_in1   <= val[0];
        ctrl_in2   <= val[1];
        repeat (hold) @(posedge mclk);
    endtask
endmodule

// ### verif/tb_gauge_calibration_mode_sequencer.sv
// Self-checking bench for the gauge calibration mode sequencer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_gauge_calibration_mode_sequencer;
    import gauge_seq_pkg::*;
    localparam int HOLD = 8;
    localparam int RUN  = 4;
    localparam int STEP = 2 * HOLD + 4;
    logic        mclk;
    logic        srst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_enable;
    logic        ctrl_in1;
    logic        ctrl_in2;
    logic        switchover_reached;
    logic        thermal_only;
    logic        ion_branch_active;
    logic        led_red;
    logic        led_green;
    logic        afc;
    logic        correct_pulse;
    logic        store_pulse;
    logic        adj_msg;
    logic [32:0] exp_q[$];
    logic [32:0] exp_v;
    logic [31:0] lfsr_s = 32'h0000_b68d;
    logic [1:0]  seqv [2][4] = '{'{2'b01, 2'b11, 2'b01, 2'b00}, '{2'b01, 2'b10, 2'b01, 2'b00}};
    int          mismatches = 0;
    int          samples_checked = 0;
    int          n_corr = 0;
    int          n_store = 0;
    int          cycles = 0;
    int          c0;
    int          s0;
    int          n;

    gauge_calibration_mode_sequencer #(.HOLD_CYCLES(HOLD), .RUN_CYCLES(RUN)) dut_u (
        .mclk(mclk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_enable(ext_enable),
        .ctrl_in1(ctrl_in1), .ctrl_in2(ctrl_in2), .switchover_reached(switchover_reached),
        .thermal_only(thermal_only), .ion_branch_active(ion_branch_active),
        .led_red(led_red), .led_green(led_green), .automatic_filament_choice(afc),
        .correct_pulse(correct_pulse), .store_pulse(store_pulse),
        .adjust_in_progress_message(adj_msg)
    );

    operator_model op_u (.mclk(mclk), .ext_enable(ext_enable), .ctrl_in1(ctrl_in1),
        .ctrl_in2(ctrl_in2));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic close_out;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge mclk);
    endtask

    // Request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never drives psel twice at once
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        lfsr_s = lfsr_next(lfsr_s);
        apb(1'b0, a, lfsr_s);
    endtask

    // Upper half random: only the low code field matters
    task automatic cmd(input logic [15:0] code);
        lfsr_s = lfsr_next(lfsr_s);
        apb(1'b1, CMD_OFFSET, {lfsr_s[15:0], code});
    endtask

    // ------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (correct_pulse === 1'b1) n_corr++;
        if (store_pulse === 1'b1) n_store++;
        if (psel && penable && !pwrite && pready === 1'b1) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_ffff_ffff;
            `CHK("apb_read", exp_v, {pslverr, prdata})
        end
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        switchover_reached = 1'b0;
        idle(6);
        srst <= 1'b0;
        idle(2);
        `CHK("afc", 1'b1, afc)
        rd(STATUS_OFFSET, {1'b0, 32'h0000_0040});
        lfsr_s = lfsr_next(lfsr_s);
        rd({3'b000, 1'b1, lfsr_s[3:2], 2'b00}, {1'b1, 32'h0000_0000});
        // Too short a step flags reject, reading clears it
        op_u.apply(1'b1, 2'b01, 3);
        op_u.apply(1'b1, 2'b00, STEP);
        rd(STATUS_OFFSET, {1'b0, 32'h0000_0840});
        rd(STATUS_OFFSET, {1'b0, 32'h0000_0040});
        op_u.apply(1'b0, 2'b01, STEP);
        `CHK("gated", 1'b0, thermal_only)
        op_u.apply(1'b0, 2'b00, 2);
        op_u.apply(1'b1, 2'b00, STEP);
        cmd(CMD_THERMAL_ONLY);
        idle(4);
        `CHK("thermal", 1'b1, thermal_only)
        rd(STATUS_OFFSET, {1'b0, 32'h0000_0051});
        switchover_reached <= 1'b1;
        idle(4);
        `CHK("ion_blocked", 1'b0, ion_branch_active)
        `CHK("red", 1'b1, led_red)
        c0 = n_corr;
        s0 = n_store;
        cmd(CMD_CORRECT);
        idle(8);
        `CHK("corr_ser", c0 + 1, n_corr)
        cmd(CMD_THERMAL_ONLY);
        idle(4);
        `CHK("store_ser", s0 + 1, n_store)
        `CHK("thermal_st", 1'b1, thermal_only)
        cmd(CMD_AUTO_RANGE);
        idle(4);
        `CHK("auto", 1'b0, thermal_only)
        `CHK("ion_on", 1'b1, ion_branch_active)
        `CHK("green", 1'b1, led_green)
        `CHK("afc_ser", 1'b1, afc)
        // Clock enable low must freeze the branch outputs
        ce <= 1'b0;
        switchover_reached <= 1'b0;
        idle(4);
        `CHK("ce_freeze", 1'b1, ion_branch_active)
        ce <= 1'b1;
        idle(4);
        `CHK("ion_off", 1'b0, ion_branch_active)
        // full scale then zero point input orders
        for (int k = 0; k < 2; k++) begin
            c0 = n_corr;
            s0 = n_store;
            op_u.apply(1'b1, seqv[k][0], STEP);
            `CHK("in_check", 1'b1, thermal_only)
            op_u.apply(1'b1, seqv[k][1], STEP);
            `CHK("in_corr", c0 + 1, n_corr)
            op_u.apply(1'b1, seqv[k][2], STEP);
            `CHK("in_store", s0 + 1, n_store)
            `CHK("in_thermal", 1'b1, thermal_only)
            op_u.apply(1'b1, seqv[k][3], STEP);
            `CHK("in_auto", 1'b0, thermal_only)
            `CHK("in_afc", 1'b1, afc)
        end
        rd(STATUS_OFFSET, {1'b0, 32'h0000_0340});
        s0 = n_store;
        apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
        idle(2);
        `CHK("panel_msg", 1'b1, adj_msg)
        n = 0;
        while (adj_msg === 1'b1 && n < RUN + 20) begin
            @(posedge mclk);
            n++;
        end
        idle(3);
        `CHK("panel_end", 1'b0, adj_msg)
        `CHK("panel_store", s0 + 1, n_store)
        `CHK("panel_auto", 1'b0, thermal_only)
        rd(CTRL_OFFSET, {1'b0, 32'h0000_0001});
        close_out();
    end
endmodule
